// File: inc/ces_defines.vh
`ifndef CES_DEFINES_VH
`define CES_DEFINES_VH

// ****************************************
// Module stop reset values
// ****************************************
`define CES_MSTP_A_RST 16'h0FFF
`define CES_MSTP_B_RST 16'hFFFF

// ****************************************
// Status register fields
// ****************************************
`define CES_CCR_I 7
`define CES_CCR_UI 6
`define CES_EXR_T 7
`define CES_EXR_MSB 2
`define CES_CCR_RST 8'h80
`define CES_EXR_RST 8'h07
`define CES_MASK_MAX 3'h7
`define CES_NMI_LVL 4'h8

// ****************************************
// Interrupt control modes
// ****************************************
`define CES_ICM0 2'h0
`define CES_ICM2 2'h2

// ****************************************
// Vector numbers and table layout
// ****************************************
`define CES_VEC_TRACE 8'h05
`define CES_VEC_NMI 8'h07
`define CES_VEC_ADDR_ERR 8'h0C
`define CES_VEC_IRQ_BASE 8'h40
`define CES_VEC_PER_BASE 8'h50
`define CES_VEC_SHIFT 2

// ****************************************
// Bus cycle kinds and masters
// ****************************************
`define CES_KIND_FETCH 2'h0
`define CES_KIND_STACK 2'h1
`define CES_KIND_DATA 2'h2
`define CES_MASTER_CPU 1'b0
`define CES_MASTER_DTC 1'b1

// ****************************************
// Address map regions
// ****************************************
`define CES_PER_LO 32'hFFFF0000
`define CES_PER_HI 32'hFFFFFFFF
`define CES_EXT_LO 32'h01000000
`define CES_EXT_HI 32'hFEFFFFFF
`define CES_PROH_LO 32'h00800000
`define CES_PROH_HI 32'h00FFFFFF

`endif

// File: hw/ces_addr_err_chk.v
`timescale 1ns/1ps
`include "ces_defines.vh"

module ces_addr_err_chk
(
    // Bus cycle attributes
    input wire bus_master,
    input wire [1:0] bus_kind,
    input wire [31:0] bus_addr,
    // CPU context
    input wire sp_odd,
    input wire single_chip,
    // Result
    output reg addr_err
);

    wire in_per;
    wire in_ext;
    wire in_proh;
    wire is_cpu;

    assign in_per = (bus_addr >= `CES_PER_LO) && (bus_addr <= `CES_PER_HI);
    assign in_ext = (bus_addr >= `CES_EXT_LO) && (bus_addr <= `CES_EXT_HI);
    assign in_proh = (bus_addr >= `CES_PROH_LO) && (bus_addr <= `CES_PROH_HI);
    assign is_cpu = (bus_master == `CES_MASTER_CPU);

    always @*
    begin
        addr_err = 1'b0;
        if (is_cpu && bus_kind == `CES_KIND_FETCH)
        begin
            addr_err = bus_addr[0] | in_per | (single_chip & in_ext) | in_proh;
        end
        else if (is_cpu && bus_kind == `CES_KIND_STACK)
        begin
            addr_err = sp_odd;
        end
        else if (is_cpu && bus_kind == `CES_KIND_DATA)
        begin
            // Odd word addresses are legal data accesses
            addr_err = (single_chip & in_ext) | in_proh;
        end
        else if (!is_cpu)
        begin
            addr_err = in_proh;
        end
    end

endmodule

// File: hw/ces_exception_seq.v
// Operation
// - Refuse all interrupts until stack pointer set
// - Module stop registers reset to 0FFF, FFFF
// - Stopped module registers ignore reads and writes
// - Trace only in control mode 2
// - Trace bit set traces every instruction other than return that is not followed by address error or interrupt entry
// - Trace ignores condition code interrupt mask
// - Trace entry sets I, clears T
// - No trace after return; restored T resumes
// - Interrupts accepted inside trace handler
// - Fetch faults: odd, peripheral, external in single-chip, prohibited
// - Stack access with odd pointer faults
// - Odd word data never faults; CPU external single-chip faults
// - Prohibited area data access faults, CPU or transfer
// - Address error entry after cycle and instruction
// - Entry stacks PC and status, fetches vector
// - Address error during address error entry ignored
// - Odd stack pointer gives undefined stacked values
// - Address error sets transfer controller error flag
// - Address error: I set; mode 2 T clear, mask 7
// - NMI, twelve pins, peripherals, own vectors
// - Two modes, eight levels for maskable sources
// - Address error vector skips base
`timescale 1ns/1ps
`include "ces_defines.vh"

module ces_exception_seq
#(
    parameter NUM_IRQ = 12,
    parameter NUM_PER = 56
)
(
    // Clock, reset, enable
    input wire ref_clk,
    input wire rst_b,
    input wire clk_en,
    // Interrupt pins and peripheral requests
    input wire nmi_pin,
    input wire [NUM_IRQ-1:0] external_request_pins_b,
    input wire [NUM_PER-1:0] periph_req,
    input wire [3*(NUM_IRQ+NUM_PER)-1:0] src_prio,
    input wire [1:0] intr_ctrl_mode,
    // CPU execution state
    input wire instr_done,
    input wire instr_is_rte,
    input wire sp_write,
    input wire sp_odd,
    input wire [31:0] pc,
    input wire [31:0] vector_base_reg,
    input wire sr_wr,
    input wire [7:0] ccr_wdata,
    input wire [7:0] exr_wdata,
    // Monitored bus cycles
    input wire bus_done,
    input wire bus_master,
    input wire [1:0] bus_kind,
    input wire [31:0] bus_addr,
    input wire single_chip,
    // Sequencer bus handshake
    input wire bus_ack,
    input wire [31:0] bus_rdata,
    // Module stop control
    input wire mstp_wr_a,
    input wire mstp_wr_b,
    input wire [15:0] mstp_wdata,
    input wire per_acc_req,
    input wire [4:0] per_acc_mod,
    // Transfer controller error clear
    input wire dtc_err_clr,
    // Status outputs
    output reg [7:0] condition_code_reg,
    output reg [7:0] extended_status_reg,
    output reg [15:0] module_stop_ctrl_a,
    output reg [15:0] module_stop_ctrl_b,
    output reg per_acc_ok_q,
    output reg dtc_err_q,
    output reg int_enable_q,
    // Exception entry outputs
    output reg stk_push_q,
    output reg [31:0] stk_data_q,
    output reg vec_rd_q,
    output reg [31:0] vec_addr_q,
    output reg pc_load_q,
    output reg [31:0] new_pc_q,
    output reg int_ack_q,
    output reg [7:0] int_ack_vec_q
);

    localparam NSRC = 1 + NUM_IRQ + NUM_PER;
    localparam NPIN = 1 + NUM_IRQ;
    localparam ST_IDLE = 2'h0;
    localparam ST_PC = 2'h1;
    localparam ST_SR = 2'h2;
    localparam ST_VEC = 2'h3;
    localparam K_AE = 2'h0;
    localparam K_INT = 2'h1;
    localparam K_TRC = 2'h2;

    // ****************************************
    // Reset release and pin synchronisers
    // ****************************************
    reg rst_m_q;
    reg rst_s_q;
    reg [NPIN-1:0] pin_s1_q;
    reg [NPIN-1:0] pin_s2_q;
    reg [NPIN-1:0] pin_s3_q;
    reg [NPIN-1:0] pin_f_q;
    wire [NPIN-1:0] pin_raw;
    wire [NPIN-1:0] pin_f_d;
    wire rst_n;

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end
        else
        begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end
    assign rst_n = rst_s_q;

    // Pin bit 0 is NMI; IRQ pins inverted so a request reads high
    assign pin_raw = {~external_request_pins_b, nmi_pin};
    // A change counts only once stages two and three agree
    assign pin_f_d = (~(pin_s2_q ^ pin_s3_q) & pin_s3_q) | ((pin_s2_q ^ pin_s3_q) & pin_f_q);

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= {NPIN{1'b0}};
            pin_s2_q <= {NPIN{1'b0}};
            pin_s3_q <= {NPIN{1'b0}};
            pin_f_q <= {NPIN{1'b0}};
        end
        else if (clk_en)
        begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_f_q <= pin_f_d;
        end
    end

    // ****************************************
    // Source eligibility and arbitration
    // ****************************************
    reg nmi_pend_q;
    reg [NUM_IRQ-1:0] irq_pend_q;
    wire [NSRC-1:0] req_all;
    wire [NSRC-1:0] elig;
    wire [4*NSRC-1:0] lvl_w;
    wire mode2;
    reg [3:0] best_lvl;
    reg [6:0] best_idx;
    reg hit;
    reg [7:0] int_vec;
    integer i;

    assign mode2 = (intr_ctrl_mode == `CES_ICM2);
    assign req_all = {periph_req, irq_pend_q, nmi_pend_q};
    assign elig[0] = req_all[0];
    assign lvl_w[3:0] = `CES_NMI_LVL;

    genvar g;
    generate
        for (g = 1; g < NSRC; g = g + 1)
        begin : g_src
            assign lvl_w[4*g+:4] = {1'b0, src_prio[3*(g-1)+:3]};
            // Mode 2 uses the priority mask; mode 0 uses the I bit
            assign elig[g] = req_all[g] & (mode2 ? (src_prio[3*(g-1)+:3] > extended_status_reg[2:0])
                                                 : ~condition_code_reg[`CES_CCR_I]);
        end
    endgenerate

    always @*
    begin
        best_lvl = 4'h0;
        best_idx = 7'h00;
        hit = 1'b0;
        for (i = 0; i < NSRC; i = i + 1)
        begin
            if (elig[i] && (!hit || lvl_w[4*i+:4] > best_lvl))
            begin
                hit = 1'b1;
                best_lvl = lvl_w[4*i+:4];
                best_idx = i[6:0];
            end
        end
        // Each source maps to a vector of its own
        if (best_idx == 7'h00)
        begin
            int_vec = `CES_VEC_NMI;
        end
        else if (best_idx <= NUM_IRQ[6:0])
        begin
            int_vec = `CES_VEC_IRQ_BASE + {1'b0, best_idx} - 8'h01;
        end
        else
        begin
            int_vec = `CES_VEC_PER_BASE + {1'b0, best_idx} - 8'h01 - NUM_IRQ[7:0];
        end
    end

    // ****************************************
    // Address error detection
    // ****************************************
    wire ae_hit;
    reg ae_pend_q;
    reg [1:0] st_q;
    reg [1:0] kind_q;
    wire ae_entry;
    wire ae_set;

    ces_addr_err_chk u_chk
    (
        .bus_master(bus_master),
        .bus_kind(bus_kind),
        .bus_addr(bus_addr),
        .sp_odd(sp_odd),
        .single_chip(single_chip),
        .addr_err(ae_hit)
    );

    assign ae_entry = (st_q != ST_IDLE) && (kind_q == K_AE);
    // Stacking faults during address error entry would recurse forever
    assign ae_set = bus_done & ae_hit & ~ae_entry;

    // ****************************************
    // Exception entry sequencer
    // ****************************************
    wire take;
    wire take_ae;
    wire take_int;
    wire take_trc;
    reg [15:0] sr_save_q;
    wire [31:0] vec_off;
    reg [7:0] vec_sel;

    assign take = clk_en & instr_done & (st_q == ST_IDLE);
    assign take_ae = take & ae_pend_q;
    assign take_int = take & ~ae_pend_q & int_enable_q & hit;
    // Trace ignores the I bit and never follows the return instruction
    assign take_trc = take & ~ae_pend_q & ~take_int & mode2 & extended_status_reg[`CES_EXR_T]
                      & ~instr_is_rte;

    always @*
    begin
        if (take_ae)
        begin
            vec_sel = `CES_VEC_ADDR_ERR;
        end
        else if (take_int)
        begin
            vec_sel = int_vec;
        end
        else
        begin
            vec_sel = `CES_VEC_TRACE;
        end
    end
    assign vec_off = {22'h000000, vec_sel, 2'h0};

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= ST_IDLE;
            kind_q <= K_AE;
            sr_save_q <= 16'h0000;
            stk_push_q <= 1'b0;
            stk_data_q <= 32'h00000000;
            vec_rd_q <= 1'b0;
            vec_addr_q <= 32'h00000000;
            pc_load_q <= 1'b0;
            new_pc_q <= 32'h00000000;
            int_ack_q <= 1'b0;
            int_ack_vec_q <= 8'h00;
        end
        else if (clk_en)
        begin
            pc_load_q <= 1'b0;
            int_ack_q <= 1'b0;
            case (st_q)
                ST_IDLE:
                begin
                    if (take_ae || take_int || take_trc)
                    begin
                        // Odd stack pointer: the pushed words are not guaranteed
                        stk_push_q <= 1'b1;
                        stk_data_q <= pc;
                        sr_save_q <= {condition_code_reg, extended_status_reg};
                        kind_q <= take_ae ? K_AE : (take_int ? K_INT : K_TRC);
                        // Address error vector is absolute; others add the base
                        vec_addr_q <= take_ae ? vec_off : vector_base_reg + vec_off;
                        int_ack_q <= take_int;
                        int_ack_vec_q <= take_int ? vec_sel : 8'h00;
                        st_q <= ST_PC;
                    end
                end
                ST_PC:
                begin
                    if (bus_ack)
                    begin
                        stk_data_q <= {16'h0000, sr_save_q};
                        st_q <= ST_SR;
                    end
                end
                ST_SR:
                begin
                    if (bus_ack)
                    begin
                        stk_push_q <= 1'b0;
                        vec_rd_q <= 1'b1;
                        st_q <= ST_VEC;
                    end
                end
                default:
                begin
                    if (bus_ack)
                    begin
                        vec_rd_q <= 1'b0;
                        pc_load_q <= 1'b1;
                        new_pc_q <= bus_rdata;
                        st_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Status registers, pending flags, module stop
    // ****************************************
    wire [4:0] sel_bit;
    wire stop_hit;

    assign sel_bit = per_acc_mod;
    assign stop_hit = per_acc_mod[4] ? module_stop_ctrl_b[sel_bit[3:0]] : module_stop_ctrl_a[sel_bit[3:0]];

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            condition_code_reg <= `CES_CCR_RST;
            extended_status_reg <= `CES_EXR_RST;
            int_enable_q <= 1'b0;
            nmi_pend_q <= 1'b0;
            irq_pend_q <= {NUM_IRQ{1'b0}};
            ae_pend_q <= 1'b0;
            dtc_err_q <= 1'b0;
            module_stop_ctrl_a <= `CES_MSTP_A_RST;
            module_stop_ctrl_b <= `CES_MSTP_B_RST;
            per_acc_ok_q <= 1'b0;
        end
        else if (clk_en)
        begin
            // Only a stack pointer load opens the interrupt path
            if (sp_write)
            begin
                int_enable_q <= 1'b1;
            end
            // New edges win over acceptance in the same cycle
            nmi_pend_q <= (pin_f_d[0] & ~pin_f_q[0]) | (nmi_pend_q & ~(take_int && best_idx == 7'h00));
            for (i = 0; i < NUM_IRQ; i = i + 1)
            begin
                irq_pend_q[i] <= (pin_f_d[i+1] & ~pin_f_q[i+1])
                                 | (irq_pend_q[i] & ~(take_int && best_idx == i[6:0] + 7'h01));
            end
            ae_pend_q <= ae_set | (ae_pend_q & ~take_ae);
            dtc_err_q <= (bus_done & ae_hit) | (dtc_err_q & ~dtc_err_clr);
            if (mstp_wr_a)
            begin
                module_stop_ctrl_a <= mstp_wdata;
            end
            if (mstp_wr_b)
            begin
                module_stop_ctrl_b <= mstp_wdata;
            end
            per_acc_ok_q <= per_acc_req & ~stop_hit;
            if (take_ae)
            begin
                condition_code_reg[`CES_CCR_I] <= 1'b1;
                if (mode2)
                begin
                    extended_status_reg[`CES_EXR_T] <= 1'b0;
                    extended_status_reg[2:0] <= `CES_MASK_MAX;
                end
            end
            else if (take_int)
            begin
                condition_code_reg[`CES_CCR_I] <= 1'b1;
                if (mode2)
                begin
                    extended_status_reg[`CES_EXR_T] <= 1'b0;
                    extended_status_reg[2:0] <= best_lvl[3] ? `CES_MASK_MAX : best_lvl[2:0];
                end
            end
            else if (take_trc)
            begin
                // UI and the priority mask keep their values
                condition_code_reg[`CES_CCR_I] <= 1'b1;
                extended_status_reg[`CES_EXR_T] <= 1'b0;
            end
            else if (sr_wr)
            begin
                // Restored T on return resumes tracing from the next instruction
                condition_code_reg <= ccr_wdata;
                extended_status_reg <= exr_wdata;
            end
        end
    end

endmodule

// File: tb/ces_seq_props.sv
`timescale 1ns/1ps
`include "ces_defines.vh"

// ****************************************
// Checker on the sequencer ports
// ****************************************
module ces_seq_props
(
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    input wire clk_en,
    // Inputs watched
    input wire sp_write,
    input wire [31:0] pc,
    input wire [31:0] vector_base_reg,
    input wire [1:0] intr_ctrl_mode,
    input wire bus_done,
    input wire bus_master,
    input wire [1:0] bus_kind,
    input wire [31:0] bus_addr,
    input wire sp_odd,
    input wire bus_ack,
    input wire [31:0] bus_rdata,
    input wire per_acc_req,
    input wire [4:0] per_acc_mod,
    input wire dtc_err_clr,
    // Outputs watched
    input wire [7:0] condition_code_reg,
    input wire [7:0] extended_status_reg,
    input wire [15:0] module_stop_ctrl_a,
    input wire [15:0] module_stop_ctrl_b,
    input wire per_acc_ok_q,
    input wire dtc_err_q,
    input wire int_enable_q,
    input wire stk_push_q,
    input wire [31:0] stk_data_q,
    input wire vec_rd_q,
    input wire [31:0] vec_addr_q,
    input wire pc_load_q,
    input wire [31:0] new_pc_q,
    input wire int_ack_q
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    logic sp_seen_q;
    wire [31:0] stop_v = {module_stop_ctrl_b, module_stop_ctrl_a};
    wire stop_bit = stop_v[per_acc_mod];
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            sp_seen_q <= 1'b0;
        else if (sp_write)
            sp_seen_q <= 1'b1;
    end
    rst_stop_a: assert property ($rose(rst_b) |-> module_stop_ctrl_a == `CES_MSTP_A_RST
        && module_stop_ctrl_b == `CES_MSTP_B_RST)
        else $error("module stop reset value wrong");
    stop_access_a: assert property (clk_en |=> per_acc_ok_q == ($past(per_acc_req) && !$past(stop_bit)))
        else $error("stopped module access answered");
    int_block_a: assert property (!sp_seen_q |-> !int_ack_q && !int_enable_q)
        else $error("interrupt accepted before stack set");
    trace_mode_a: assert property ($rose(stk_push_q) && $past(intr_ctrl_mode) == `CES_ICM0
        |-> vec_addr_q != vector_base_reg + 32'h14)
        else $error("trace taken in mode 0");
    trace_status_a: assert property ($rose(stk_push_q) && vec_addr_q == vector_base_reg + 32'h14
        |-> condition_code_reg[7] && !extended_status_reg[7] && condition_code_reg[6] == $past(condition_code_reg[6])
        && extended_status_reg[2:0] == $past(extended_status_reg[2:0]))
        else $error("trace entry status wrong");
    ae_status_a: assert property ($rose(stk_push_q) && vec_addr_q == 32'h30 |-> condition_code_reg[7]
        && ($past(intr_ctrl_mode) != `CES_ICM2 || (extended_status_reg[2:0] == 3'h7 && !extended_status_reg[7])))
        else $error("address error entry status wrong");
    ae_flag_a: assert property (bus_done && clk_en && bus_kind == `CES_KIND_STACK && sp_odd |=> dtc_err_q)
        else $error("odd stack access not flagged");
    flag_cause_a: assert property ($rose(dtc_err_q) |-> $past(bus_done))
        else $error("error flag set without bus cycle");
    data_word_a: assert property (bus_done && bus_kind == `CES_KIND_DATA && bus_master == `CES_MASTER_CPU
        && bus_addr < `CES_PROH_LO && !dtc_err_clr |=> dtc_err_q == $past(dtc_err_q))
        else $error("word data access flagged");
    stack_pc_a: assert property ($rose(stk_push_q) |-> stk_data_q == $past(pc))
        else $error("first push is not pc");
    vec_load_a: assert property (pc_load_q |-> $past(vec_rd_q) && $past(bus_ack)
        && new_pc_q == $past(bus_rdata))
        else $error("pc not loaded from vector read");
endmodule

bind ces_exception_seq ces_seq_props chk_u (.*);

// File: tb/ces_bus_partner.sv
`timescale 1ns/1ps

// ****************************************
// Bus side: answers stack pushes and vector reads
// ****************************************
module ces_bus_partner
(
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Requests
    input wire stk_push_q,
    input wire [31:0] stk_data_q,
    input wire vec_rd_q,
    input wire [31:0] vec_addr_q,
    input wire [3:0] wait_cyc,
    // Answers
    output logic bus_ack,
    output logic [31:0] bus_rdata
);
    logic [3:0] cnt_q;
    logic wsel_q;
    logic [31:0] word_q [0:1];
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= 4'h0;
            wsel_q <= 1'b0;
            bus_ack <= 1'b0;
            bus_rdata <= 32'h0;
        end
        else
        begin
            bus_ack <= 1'b0;
            // Released data lines must not look like a valid vector
            bus_rdata <= ~bus_rdata;
            if ((stk_push_q || vec_rd_q) && !bus_ack)
            begin
                if (cnt_q == wait_cyc)
                begin
                    bus_ack <= 1'b1;
                    cnt_q <= 4'h0;
                    if (vec_rd_q)
                        bus_rdata <= {16'h8000, vec_addr_q[15:0]};
                    if (stk_push_q)
                        word_q[wsel_q] <= stk_data_q;
                    if (stk_push_q)
                        wsel_q <= ~wsel_q;
                end
                else
                    cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule

// File: tb/ces_exception_seq_tb.sv
`timescale 1ns/1ps
`include "ces_defines.vh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; $display("[ERR] %s exp %h got %h", n, e, a); end end

module ces_exception_seq_tb;
    localparam [31:0] VECTOR_BASE_REG = 32'h00001000;
    localparam [203:0] PRIO = 204'h5 << 45;
    localparam [1:0] KF = `CES_KIND_FETCH;
    localparam [1:0] KS = `CES_KIND_STACK;
    localparam [1:0] KD = `CES_KIND_DATA;
    logic ref_clk, rst_b, nmi_pin, instr_done, instr_is_rte, sp_write, sp_odd, sr_wr, bus_done, bus_master;
    logic single_chip, bus_ack, mstp_wr_a, mstp_wr_b, per_acc_req, dtc_err_clr, per_acc_ok_q, dtc_err_q;
    logic stk_push_q, vec_rd_q, pc_load_q, int_ack_q;
    logic [1:0] intr_ctrl_mode, bus_kind;
    logic [3:0] wait_cyc;
    logic [4:0] per_acc_mod;
    logic [7:0] ccr_wdata, exr_wdata, condition_code_reg, extended_status_reg, int_ack_vec_q;
    logic [15:0] mstp_wdata, module_stop_ctrl_a, module_stop_ctrl_b;
    logic [31:0] pc, bus_addr, bus_rdata, stk_data_q, vec_addr_q, new_pc_q;
    logic [55:0] periph_req;
    int checks = 0;
    int bad_count = 0;
    int cyc_cnt = 0;

    ces_exception_seq dut_u (.*, .clk_en(1'b1), .external_request_pins_b({12{1'b1}}), .src_prio(PRIO),
        .vector_base_reg(VECTOR_BASE_REG), .int_enable_q());
    ces_bus_partner p_u (.*);

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task stop_test;
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 3000)
        begin
            bad_count++;
            stop_test();
        end
    end
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task acc(input logic [4:0] m, input logic e);
        per_acc_mod = m;
        per_acc_req = 1'b1;
        tick(1);
        per_acc_req = 1'b0;
        `CHK("acc_ok", e, per_acc_ok_q)
        tick(1);
    endtask
    task setsr(input logic [7:0] c, input logic [7:0] e);
        ccr_wdata = c;
        exr_wdata = e;
        sr_wr = 1'b1;
        tick(1);
        sr_wr = 1'b0;
        tick(1);
    endtask
    task no_entry(input logic return_from_exception);
        instr_is_rte = return_from_exception;
        instr_done = 1'b1;
        tick(1);
        instr_done = 1'b0;
        instr_is_rte = 1'b0;
        `CHK("no_entry", 1'b0, stk_push_q)
        tick(1);
    endtask
    task run_entry(input logic [31:0] va, input logic [7:0] oc, oe, nc, ne, iv, input logic inj);
        int n;
        instr_done = 1'b1;
        tick(1);
        instr_done = 1'b0;
        `CHK("push", 1'b1, stk_push_q)
        `CHK("vec_addr", va, vec_addr_q)
        `CHK("ccr", nc, condition_code_reg)
        `CHK("exr", ne, extended_status_reg)
        `CHK("int_ack", iv != 8'h00, int_ack_q)
        if (iv != 8'h00)
            `CHK("ack_vec", iv, int_ack_vec_q)
        if (inj)
        begin
            bus_kind = KS;
            sp_odd = 1'b1;
            bus_done = 1'b1;
            tick(1);
            bus_done = 1'b0;
            sp_odd = 1'b0;
        end
        n = 0;
        while (pc_load_q !== 1'b1 && n < 60)
        begin
            tick(1);
            n++;
        end
        `CHK("new_pc", {16'h8000, va[15:0]}, new_pc_q)
        `CHK("push_pc", pc, p_u.word_q[0])
        `CHK("push_sr", {16'h0000, oc, oe}, p_u.word_q[1])
        tick(1);
    endtask
    task bcyc(input logic m, input logic [1:0] k, input logic [31:0] a, input logic so, sc, e);
        bus_master = m;
        bus_kind = k;
        bus_addr = a;
        sp_odd = so;
        single_chip = sc;
        bus_done = 1'b1;
        tick(1);
        bus_done = 1'b0;
        sp_odd = 1'b0;
        `CHK("err_flag", e, dtc_err_q)
        dtc_err_clr = 1'b1;
        tick(1);
        dtc_err_clr = 1'b0;
    endtask
    task t_reset;
        `CHK("stop_a", 16'h0FFF, module_stop_ctrl_a)
        `CHK("stop_b", 16'hFFFF, module_stop_ctrl_b)
        `CHK("ccr_rst", 8'h80, condition_code_reg)
        acc(5'd0, 1'b0);
        acc(5'd12, 1'b1);
        acc(5'd16, 1'b0);
        mstp_wdata = 16'h0000;
        mstp_wr_a = 1'b1;
        tick(1);
        mstp_wr_a = 1'b0;
        acc(5'd0, 1'b1);
        mstp_wdata = 16'hFFFE;
        mstp_wr_b = 1'b1;
        tick(1);
        mstp_wr_b = 1'b0;
        acc(5'd16, 1'b1);
        acc(5'd17, 1'b0);
    endtask
    task t_nmi;
        nmi_pin = 1'b1;
        tick(8);
        no_entry(1'b0);
        sp_write = 1'b1;
        tick(1);
        sp_write = 1'b0;
        pc = 32'h00002000;
        run_entry(VECTOR_BASE_REG + 32'h1C, 8'h80, 8'h07, 8'h80, 8'h07, 8'h07, 1'b0);
        nmi_pin = 1'b0;
    endtask
    task t_trace;
        setsr(8'h00, 8'h87);
        no_entry(1'b0);
        setsr(8'h00, 8'h07);
        intr_ctrl_mode = `CES_ICM2;
        wait_cyc = 4'h3;
        setsr(8'hC0, 8'h80);
        pc = 32'h00002100;
        run_entry(VECTOR_BASE_REG + 32'h14, 8'hC0, 8'h80, 8'hC0, 8'h00, 8'h00, 1'b0);
        setsr(8'hC0, 8'h80);
        no_entry(1'b1);
        pc = 32'h00002104;
        run_entry(VECTOR_BASE_REG + 32'h14, 8'hC0, 8'h80, 8'hC0, 8'h00, 8'h00, 1'b0);
        wait_cyc = 4'h0;
        periph_req[3] = 1'b1;
        pc = 32'h00002200;
        run_entry(VECTOR_BASE_REG + 32'h14C, 8'hC0, 8'h00, 8'hC0, 8'h05, 8'h53, 1'b0);
        periph_req = '0;
    endtask
    task t_addr_err;
        bcyc(1'b0, KF, 32'h00001000, 1'b0, 1'b1, 1'b0);
        bcyc(1'b0, KF, 32'h00001001, 1'b0, 1'b1, 1'b1);
        bcyc(1'b0, KF, 32'hFFFF0010, 1'b0, 1'b1, 1'b1);
        bcyc(1'b0, KF, 32'h01000000, 1'b0, 1'b1, 1'b1);
        bcyc(1'b0, KF, 32'h01000000, 1'b0, 1'b0, 1'b0);
        bcyc(1'b0, KF, 32'h00800000, 1'b0, 1'b1, 1'b1);
        bcyc(1'b0, KS, 32'h00002000, 1'b1, 1'b1, 1'b1);
        bcyc(1'b0, KS, 32'h00002000, 1'b0, 1'b1, 1'b0);
        bcyc(1'b0, KD, 32'h00001001, 1'b0, 1'b1, 1'b0);
        bcyc(1'b0, KD, 32'hFEFFFFFF, 1'b0, 1'b1, 1'b1);
        bcyc(1'b0, KD, 32'h00FFFFFE, 1'b0, 1'b0, 1'b1);
        bcyc(1'b1, KD, 32'h00001001, 1'b0, 1'b1, 1'b0);
        bcyc(1'b1, KD, 32'h01000000, 1'b0, 1'b1, 1'b0);
        bcyc(1'b1, KD, 32'h00800000, 1'b0, 1'b1, 1'b1);
        `CHK("wait_instr", 1'b0, stk_push_q)
        pc = 32'h00002300;
        run_entry(32'h00000030, 8'hC0, 8'h05, 8'hC0, 8'h07, 8'h00, 1'b1);
        no_entry(1'b0);
    endtask

    initial
    begin
        {rst_b, nmi_pin, instr_done, instr_is_rte, sp_write, sp_odd, sr_wr, bus_done, bus_master} = '0;
        {single_chip, mstp_wr_a, mstp_wr_b, per_acc_req, dtc_err_clr, intr_ctrl_mode, bus_kind} = '0;
        {wait_cyc, per_acc_mod, ccr_wdata, exr_wdata, mstp_wdata, pc, bus_addr, periph_req} = '0;
        repeat (4) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        tick(4);
        t_reset();
        t_nmi();
        t_trace();
        t_addr_err();
        stop_test();
    end
endmodule
